// *** rtl/rcpc_clk_switch.sv ***
// Break-before-make select enables for the system clock source
module rcpc_clk_switch
   import rcpc_pkg::*;
#(
   parameter int GAP = SW_GAP_CYCLES
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic sel_pll_i,
   output logic      osc_en_o,
   output logic      pll_en_o
);

   rcpc_sw_state_e state_q, state_d;
   logic [7:0]     gap_q, gap_d;
   logic           osc_en_d, pll_en_d;

   ////////////////////////////////////////////////////////////////////////
   // Next state: drop the old enable, wait the gap, raise the new one
   always_comb begin
      state_d  = state_q;
      gap_d    = gap_q;
      case (state_q)
         CS_OSC: begin
            if (sel_pll_i) begin
               state_d = CS_TO_PLL;
               gap_d   = 8'(GAP);
            end
         end
         CS_TO_PLL: begin
            if (gap_q != 8'h00) gap_d = gap_q - 8'h01;
            else state_d = sel_pll_i ? CS_PLL : CS_OSC;
         end
         CS_PLL: begin
            if (!sel_pll_i) begin
               state_d = CS_TO_OSC;
               gap_d   = 8'(GAP);
            end
         end
         CS_TO_OSC: begin
            if (gap_q != 8'h00) gap_d = gap_q - 8'h01;
            else state_d = sel_pll_i ? CS_PLL : CS_OSC;
         end
         default: begin
            state_d = CS_OSC;
            gap_d   = 8'h00;
         end
      endcase
      osc_en_d = (state_d == CS_OSC);
      pll_en_d = (state_d == CS_PLL);
   end

   // State and enable registers, oscillator path after reset
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state_q  <= CS_OSC;
         gap_q    <= 8'h00;
         osc_en_o <= 1'b1;
         pll_en_o <= 1'b0;
      end else begin
         state_q  <= state_d;
         gap_q    <= gap_d;
         osc_en_o <= osc_en_d;
         pll_en_o <= pll_en_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   AST_NO_OVERLAP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !(osc_en_o && pll_en_o))
      else $error("both clock sources enabled");
   AST_GAP_BEFORE_PLL: assert property (@(posedge clk_i)
      disable iff (!rst_n_i)
      $rose(pll_en_o) |-> !$past(osc_en_o))
      else $error("pll enabled without a gap");

endmodule

// *** rtl/rcpc_pkg.sv ***
// Constants and types for the run clock and PLL configuration block
package rcpc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses
   localparam int          ADDR_W      = 12;
   localparam logic [11:0] RCC_OFFS    = 12'h060;
   localparam logic [11:0] PLLCFG_OFFS = 12'h064;
   localparam logic [11:0] RUN_CLOCK_CONFIG_EXT_OFFS   = 12'h070;

   // Reset values and write masks
   localparam logic [31:0] RCC_RESET   = 32'h0780_3ad1;
   localparam logic [31:0] RCC_WMASK   = 32'h0fc0_2bf3;
   localparam logic [31:0] RCC_ONES    = 32'h0000_1000;
   localparam logic [31:0] RUN_CLOCK_CONFIG_EXT_RESET  = 32'h0780_2810;
   localparam logic [31:0] RUN_CLOCK_CONFIG_EXT_WMASK  = 32'h9f80_2870;

   // Field positions
   localparam int RCC_PLL_POWER_DOWN_BIT  = 13;
   localparam int RCC_BYPASS_BIT = 11;
   localparam int RCC_CRYSTAL_CODE_LSB   = 6;
   localparam int RCC_CRYSTAL_CODE_MSB   = 9;
   localparam int RCC_DIV_LSB    = 23;
   localparam int RCC_DIV_MSB    = 26;
   localparam int RCC_OSC_LSB    = 4;
   localparam int RCC_OSC_MSB    = 5;
   localparam int RUN_CLOCK_CONFIG_EXT_USE_BIT   = 31;
   localparam int RUN_CLOCK_CONFIG_EXT_DIV_LSB   = 23;
   localparam int RUN_CLOCK_CONFIG_EXT_DIV_MSB   = 28;
   localparam int RUN_CLOCK_CONFIG_EXT_OSC_LSB   = 4;
   localparam int RUN_CLOCK_CONFIG_EXT_OSC_MSB   = 6;
   localparam int PLLCFG_F_LSB   = 5;
   localparam int PLLCFG_F_MSB   = 13;
   localparam int PLLCFG_R_MSB   = 4;

   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Crystal codes
   localparam logic [3:0] CRYSTAL_CODE_RESET   = 4'hb;
   localparam logic [3:0] CRYSTAL_CODE_PLL_MIN = 4'h4;
   localparam int         PLL_TARGET_MHZ = 400;

   // PLL F and R per crystal code, index 15 first; codes below 0x4 give 0
   localparam logic [15:0][8:0] PLL_F_TAB = {
      9'h031, 9'h032, 9'h036, 9'h041, 9'h0c8, 9'h04e, 9'h050, 9'h051,
      9'h062, 9'h064, 9'h06d, 9'h070, 9'h000, 9'h000, 9'h000, 9'h000};
   localparam logic [15:0][4:0] PLL_R_TAB = {
      5'h00, 5'h00, 5'h00, 5'h00, 5'h02, 5'h00, 5'h00, 5'h00,
      5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00};

   // Clock switch sequencing
   localparam int SW_GAP_CYCLES = 2;

   typedef enum {CS_OSC, CS_TO_PLL, CS_PLL, CS_TO_OSC} rcpc_sw_state_e;

endpackage

// *** rtl/rcpc_top.sv ***
// Run clock configuration registers with AXI4-Lite access
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
module rcpc_top
   import rcpc_pkg::*;
(
   input  wire logic              MCLK_I,
   input  wire logic              RST_N_I,
   input  wire logic [ADDR_W-1:0] AWADDR_I,
   input  wire logic              AWVALID_I,
   output logic                   AWREADY_O,
   input  wire logic [31:0]       WDATA_I,
   input  wire logic [3:0]        WSTRB_I,
   input  wire logic              WVALID_I,
   output logic                   WREADY_O,
   output logic [1:0]             BRESP_O,
   output logic                   BVALID_O,
   input  wire logic              BREADY_I,
   input  wire logic [ADDR_W-1:0] ARADDR_I,
   input  wire logic              ARVALID_I,
   output logic                   ARREADY_O,
   output logic [31:0]            RDATA_O,
   output logic [1:0]             RRESP_O,
   output logic                   RVALID_O,
   input  wire logic              RREADY_I,
   output logic                   PLL_PLL_POWER_DOWN_O,
   output logic [5:0]             SYS_DIV_O,
   output logic [2:0]             OSC_SRC_O,
   output logic [3:0]             CRYSTAL_CODE_O,
   output logic [8:0]             PLL_F_O,
   output logic [4:0]             PLL_R_O,
   output logic                   SRC_OSC_EN_O,
   output logic                   SRC_PLL_EN_O
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [31:0]       rcc_q, rcc_d;
   logic [31:0]       run_clock_config_ext_q, run_clock_config_ext_d;
   logic [8:0]        pll_f_q, pll_f_d;
   logic [4:0]        pll_r_q, pll_r_d;
   logic [ADDR_W-1:0] awaddr_q, awaddr_d;
   logic [31:0]       wdata_q, wdata_d;
   logic [3:0]        wstrb_q, wstrb_d;
   logic              aw_hold_q, aw_hold_d;
   logic              w_hold_q, w_hold_d;
   logic              bvalid_q, bvalid_d;
   logic [1:0]        bresp_q, bresp_d;
   logic              awready_q, awready_d;
   logic              wready_q, wready_d;
   logic              arready_q, arready_d;
   logic              rvalid_q, rvalid_d;
   logic [31:0]       rdata_q, rdata_d;
   logic [1:0]        rresp_q, rresp_d;
   logic              pll_power_down_q, pll_power_down_d;
   logic [5:0]        div_q, div_d;
   logic [2:0]        osc_q, osc_d;
   logic [3:0]        crystal_code_q, crystal_code_d;
   logic              hs_aw, hs_w, hs_ar, do_wr;
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0]       wr_data, byte_mask;
   logic [3:0]        wr_strb;
   logic              use_ext, eff_bypass, sel_pll;

   ////////////////////////////////////////////////////////////////////////
   // Write channel: hold address and data, write once both are held
   always_comb begin
      hs_aw     = AWVALID_I && awready_q;
      hs_w      = WVALID_I && wready_q;
      aw_hold_d = aw_hold_q || hs_aw;
      w_hold_d  = w_hold_q || hs_w;
      awaddr_d  = hs_aw ? AWADDR_I : awaddr_q;
      wdata_d   = hs_w ? WDATA_I : wdata_q;
      wstrb_d   = hs_w ? WSTRB_I : wstrb_q;
      wr_addr   = awaddr_d;
      wr_data   = wdata_d;
      wr_strb   = wstrb_d;
      do_wr     = aw_hold_d && w_hold_d && !bvalid_q;
      bvalid_d  = bvalid_q && !BREADY_I;
      bresp_d   = bresp_q;
      if (do_wr) begin
         aw_hold_d = 1'b0;
         w_hold_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = RESP_OKAY;
         if (wr_addr != RCC_OFFS && wr_addr != RUN_CLOCK_CONFIG_EXT_OFFS &&
             wr_addr != PLLCFG_OFFS) begin
            bresp_d = RESP_SLVERR;
         end
      end
      awready_d = !aw_hold_d && !bvalid_d;
      wready_d  = !w_hold_d && !bvalid_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // Register update with byte strobes; read-only bits stay fixed
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         byte_mask[i*8 +: 8] = {8{wr_strb[i]}};
      end
      rcc_d  = rcc_q;
      run_clock_config_ext_d = run_clock_config_ext_q;
      if (do_wr && wr_addr == RCC_OFFS) begin
         rcc_d = (rcc_q & ~(byte_mask & RCC_WMASK)) |
                 (wr_data & byte_mask & RCC_WMASK);
      end
      if (do_wr && wr_addr == RUN_CLOCK_CONFIG_EXT_OFFS) begin
         run_clock_config_ext_d = (run_clock_config_ext_q & ~(byte_mask & RUN_CLOCK_CONFIG_EXT_WMASK)) |
                  (wr_data & byte_mask & RUN_CLOCK_CONFIG_EXT_WMASK);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // PLL F and R recomputed whenever the crystal code changes
   always_comb begin
      crystal_code_d  = rcc_q[RCC_CRYSTAL_CODE_MSB:RCC_CRYSTAL_CODE_LSB];
      pll_f_d = pll_f_q;
      pll_r_d = pll_r_q;
      if (crystal_code_d != crystal_code_q) begin
         pll_f_d = PLL_F_TAB[crystal_code_d];
         pll_r_d = PLL_R_TAB[crystal_code_d];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read channel: one read at a time, data one cycle after address
   always_comb begin
      hs_ar    = ARVALID_I && arready_q;
      rvalid_d = rvalid_q && !RREADY_I;
      rdata_d  = rdata_q;
      rresp_d  = rresp_q;
      if (hs_ar) begin
         rvalid_d = 1'b1;
         rresp_d  = RESP_OKAY;
         rdata_d  = 32'h0000_0000;
         case (ARADDR_I)
            RCC_OFFS: rdata_d = (rcc_q & RCC_WMASK) | RCC_ONES;
            RUN_CLOCK_CONFIG_EXT_OFFS: rdata_d = run_clock_config_ext_q & RUN_CLOCK_CONFIG_EXT_WMASK;
            PLLCFG_OFFS: begin
               rdata_d[PLLCFG_F_MSB:PLLCFG_F_LSB] = pll_f_q;
               rdata_d[PLLCFG_R_MSB:0]            = pll_r_q;
            end
            default: rresp_d = RESP_SLVERR;
         endcase
      end
      arready_d = !rvalid_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // Effective clock controls; the extended register overrides when used
   always_comb begin
      use_ext = run_clock_config_ext_q[RUN_CLOCK_CONFIG_EXT_USE_BIT];
      if (use_ext) begin
         div_d      = run_clock_config_ext_q[RUN_CLOCK_CONFIG_EXT_DIV_MSB:RUN_CLOCK_CONFIG_EXT_DIV_LSB];
         pll_power_down_d    = run_clock_config_ext_q[RCC_PLL_POWER_DOWN_BIT];
         eff_bypass = run_clock_config_ext_q[RCC_BYPASS_BIT];
         osc_d      = run_clock_config_ext_q[RUN_CLOCK_CONFIG_EXT_OSC_MSB:RUN_CLOCK_CONFIG_EXT_OSC_LSB];
      end else begin
         div_d      = {2'b00, rcc_q[RCC_DIV_MSB:RCC_DIV_LSB]};
         pll_power_down_d    = rcc_q[RCC_PLL_POWER_DOWN_BIT];
         eff_bypass = rcc_q[RCC_BYPASS_BIT];
         osc_d      = {1'b0, rcc_q[RCC_OSC_MSB:RCC_OSC_LSB]};
      end
      sel_pll = !eff_bypass;
   end

   ////////////////////////////////////////////////////////////////////////
   // All state registers
   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         rcc_q     <= RCC_RESET;
         run_clock_config_ext_q    <= RUN_CLOCK_CONFIG_EXT_RESET;
         crystal_code_q    <= CRYSTAL_CODE_RESET;
         pll_f_q   <= PLL_F_TAB[CRYSTAL_CODE_RESET];
         pll_r_q   <= PLL_R_TAB[CRYSTAL_CODE_RESET];
         awaddr_q  <= '0;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= RESP_OKAY;
         pll_power_down_q   <= 1'b1;
         div_q     <= {2'b00, RCC_RESET[RCC_DIV_MSB:RCC_DIV_LSB]};
         osc_q     <= {1'b0, RCC_RESET[RCC_OSC_MSB:RCC_OSC_LSB]};
      end else begin
         rcc_q     <= rcc_d;
         run_clock_config_ext_q    <= run_clock_config_ext_d;
         crystal_code_q    <= crystal_code_d;
         pll_f_q   <= pll_f_d;
         pll_r_q   <= pll_r_d;
         awaddr_q  <= awaddr_d;
         wdata_q   <= wdata_d;
         wstrb_q   <= wstrb_d;
         aw_hold_q <= aw_hold_d;
         w_hold_q  <= w_hold_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         awready_q <= awready_d;
         wready_q  <= wready_d;
         arready_q <= arready_d;
         rvalid_q  <= rvalid_d;
         rdata_q   <= rdata_d;
         rresp_q   <= rresp_d;
         pll_power_down_q   <= pll_power_down_d;
         div_q     <= div_d;
         osc_q     <= osc_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Glitch-free source select
   rcpc_clk_switch #(
      .GAP (SW_GAP_CYCLES)
   ) u_switch (
      .clk_i     (MCLK_I),
      .rst_n_i   (RST_N_I),
      .sel_pll_i (sel_pll),
      .osc_en_o  (SRC_OSC_EN_O),
      .pll_en_o  (SRC_PLL_EN_O)
   );

   // Outputs straight from registers
   assign AWREADY_O      = awready_q;
   assign WREADY_O       = wready_q;
   assign BVALID_O       = bvalid_q;
   assign BRESP_O        = bresp_q;
   assign ARREADY_O      = arready_q;
   assign RVALID_O       = rvalid_q;
   assign RDATA_O        = rdata_q;
   assign RRESP_O        = rresp_q;
   assign PLL_PLL_POWER_DOWN_O    = pll_power_down_q;
   assign SYS_DIV_O      = div_q;
   assign OSC_SRC_O      = osc_q;
   assign CRYSTAL_CODE_O = crystal_code_q;
   assign PLL_F_O        = pll_f_q;
   assign PLL_R_O        = pll_r_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RST_N_I);

   AST_EXT_DIV: assert property (
      run_clock_config_ext_q[RUN_CLOCK_CONFIG_EXT_USE_BIT] |=> SYS_DIV_O == $past(run_clock_config_ext_q[28:23]))
      else $error("extended divisor not used");
   AST_PLL_POWER_DOWN_FOLLOW: assert property (
      !run_clock_config_ext_q[RUN_CLOCK_CONFIG_EXT_USE_BIT] |=> PLL_PLL_POWER_DOWN_O == $past(rcc_q[13]))
      else $error("power-down output does not follow bit 13");
   AST_BYPASS_OSC: assert property (
      $rose(eff_bypass) ##1 eff_bypass[*6] |-> SRC_OSC_EN_O)
      else $error("oscillator not selected under bypass");
   AST_PLL_PATH: assert property (
      $fell(eff_bypass) ##1 (!eff_bypass)[*6] |-> SRC_PLL_EN_O)
      else $error("pll path not selected without bypass");
   AST_CRYSTAL_CODE_RESET: assert property (
      $past(!RST_N_I) |-> CRYSTAL_CODE_O == 4'hb && PLL_F_O == 9'h0c8)
      else $error("crystal code reset value wrong");
   AST_CRYSTAL_CODE_FIELD: assert property (
      1'b1 |=> CRYSTAL_CODE_O == $past(rcc_q[9:6]))
      else $error("crystal code output stale");
   AST_PLL_RECOMPUTE: assert property (
      $changed(rcc_q[9:6]) |-> ##[1:2] (PLL_F_O == PLL_F_TAB[crystal_code_q] &&
      PLL_R_O == PLL_R_TAB[crystal_code_q]))
      else $error("pll settings not recomputed");
   AST_RCC_READ_FIXED: assert property (
      (hs_ar && ARADDR_I == RCC_OFFS) |=>
      RVALID_O && RDATA_O[12] && RDATA_O[21:14] == 8'h00 && !RDATA_O[10])
      else $error("reserved bits read wrong");
   AST_WR_RESP: assert property (
      (hs_aw && hs_w && !bvalid_q) |=> BVALID_O ##0 !AWREADY_O)
      else $error("write response missing");

   COV_TO_PLL: cover property ($rose(SRC_PLL_EN_O));
   COV_EXT_USED: cover property ($rose(run_clock_config_ext_q[RUN_CLOCK_CONFIG_EXT_USE_BIT]));
   COV_CRYSTAL_CODE_CHANGE: cover property ($changed(crystal_code_q));
   COV_READ: cover property (RVALID_O && RREADY_I);

endmodule

// *** test/rcpc_top_tb_top.sv ***
// Self-checking bench for the run clock configuration block
module rcpc_top_tb_top
   import rcpc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic [31:0] rexp;
      logic [1:0]  resp;
   } rcpc_row_s;

   logic              mclk, rst_n;
   logic [11:0]       awaddr, araddr;
   logic              awvalid, wvalid, bready, arvalid, rready;
   logic [31:0]       wdata;
   logic [3:0]        wstrb;
   logic              awready, wready, bvalid, arready, rvalid;
   logic [1:0]        bresp, rresp, br, rr;
   logic [31:0]       rdata, rd;
   logic              pll_pll_power_down, osc_en, pll_en;
   logic [5:0]        sys_div;
   logic [2:0]        osc_src;
   logic [3:0]        crystal_code;
   logic [8:0]        pll_f;
   logic [4:0]        pll_r;
   int                fail_count, checks, cyc;
   rcpc_row_s         rows [16];

   ////////////////////////////////////////////////////////////////////////
   // Clock, design and hang guard
   initial mclk = 1'b0;
   always #2 mclk = ~mclk;

   rcpc_top DUT (.MCLK_I(mclk), .RST_N_I(rst_n), .AWADDR_I(awaddr),
      .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata),
      .WSTRB_I(wstrb), .WVALID_I(wvalid), .WREADY_O(wready),
      .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
      .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
      .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid),
      .RREADY_I(rready), .PLL_PLL_POWER_DOWN_O(pll_pll_power_down), .SYS_DIV_O(sys_div),
      .OSC_SRC_O(osc_src), .CRYSTAL_CODE_O(crystal_code), .PLL_F_O(pll_f),
      .PLL_R_O(pll_r), .SRC_OSC_EN_O(osc_en), .SRC_PLL_EN_O(pll_en));

   // Cycle ceiling well above the expected run
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         end_of_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // Write address and data offered together, each released when taken
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                         input logic [3:0] s, output logic [1:0] r);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done  = 1'b0;
      @(posedge mclk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wstrb   <= s;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge mclk);
         if (!aw_done && awready === 1'b1) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_done && wready === 1'b1) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge mclk);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      @(posedge mclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      @(posedge mclk);
      while (arready !== 1'b1) @(posedge mclk);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge mclk);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   // Reset values at the ports and in the registers
   task automatic reset_check();
      axi_rd(RCC_OFFS, rd, rr);
      check(rd, 32'h0780_3ad1, "rcc reset");
      axi_rd(RUN_CLOCK_CONFIG_EXT_OFFS, rd, rr);
      check(rd, 32'h0780_2810, "run_clock_config_ext reset");
      axi_rd(PLLCFG_OFFS, rd, rr);
      check(rd, 32'h0000_1902, "pllcfg reset");
      check(pll_pll_power_down, 1'b1, "pll_power_down reset");
      check(crystal_code, 4'hb, "crystal reset");
      check({osc_en, pll_en}, 2'b10, "source reset");
   endtask

   // Write, then watch the source enables through the handover
   task automatic wr_sw(input logic [11:0] a, input logic [31:0] d,
                        input logic to_pll);
      int lowcnt;
      logic both;
      lowcnt = 0;
      both   = 1'b0;
      axi_wr(a, d, 4'hf, br);
      repeat (30) begin
         @(posedge mclk);
         if (osc_en === 1'b1 && pll_en === 1'b1) both = 1'b1;
         if (osc_en === 1'b0 && pll_en === 1'b0) lowcnt++;
      end
      check(both, 1'b0, "both sources on");
      check(lowcnt >= SW_GAP_CYCLES, 1'b1, "no break gap");
      check({osc_en, pll_en}, {~to_pll, to_pll}, "source end");
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst_n = 1'b0; awaddr = '0; awvalid = 1'b0; wdata = '0; wstrb = '0;
      wvalid = 1'b0; bready = 1'b0; araddr = '0; arvalid = 1'b0;
      rready = 1'b0; fail_count = 0; checks = 0; cyc = 0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      reset_check();
      $display("test reset done");

      // Rows: all ones, bypass bit alone, crystal codes 0x4 to 0xf, read-only, unmapped
      rows[0] = '{RCC_OFFS, 32'hffff_ffff, 32'h0fc0_3bf3, RESP_OKAY};
      // Low crystal codes only with the bypass set, PLL unused
      rows[1] = '{RCC_OFFS, 32'h0000_0800, 32'h0000_1800, RESP_OKAY};
      for (int c = 4; c < 16; c++) begin
         rows[c-2].addr  = RCC_OFFS;
         rows[c-2].wdata = (RCC_RESET & ~32'h0000_03c0) | (32'(c) << 6);
         rows[c-2].rexp  = rows[c-2].wdata;
         rows[c-2].resp  = RESP_OKAY;
      end
      rows[14] = '{PLLCFG_OFFS, 32'hffff_ffff,
                   {18'h0, PLL_F_TAB[15], PLL_R_TAB[15]}, RESP_OKAY};
      rows[15] = '{12'h100, 32'hffff_ffff, 32'h0, RESP_SLVERR};
      foreach (rows[i]) begin
         axi_wr(rows[i].addr, rows[i].wdata, 4'hf, br);
         check(br, rows[i].resp, "write resp");
         axi_rd(rows[i].addr, rd, rr);
         check(rr, rows[i].resp, "read resp");
         check(rd, rows[i].rexp, "read data");
         if (rows[i].addr == RCC_OFFS) begin
            check(crystal_code, rows[i].rexp[9:6], "crystal out");
            check(pll_f, PLL_F_TAB[rows[i].rexp[9:6]], "pll f");
            check(pll_r, PLL_R_TAB[rows[i].rexp[9:6]], "pll r");
            check(pll_pll_power_down, rows[i].rexp[13], "pll_power_down out");
            check(sys_div, {2'b0, rows[i].rexp[26:23]}, "div");
            check(osc_src, {1'b0, rows[i].rexp[5:4]}, "osc");
         end
      end
      $display("test rows done");

      // Byte lane 1 alone rewrites only the writable bits of bits 15:8;
      // bypass stays set since the crystal code drops to 0x3
      axi_wr(RCC_OFFS, 32'h0000_0800, 4'b0010, br);
      axi_rd(RCC_OFFS, rd, rr);
      check(rd, 32'h0780_18d1, "strobe lane");
      check({osc_en, pll_en}, 2'b10, "strobe source");
      $display("test strobe done");

      // Source handover both ways from the base register
      wr_sw(RCC_OFFS, RCC_RESET & ~32'h0000_2800, 1'b1);
      wr_sw(RCC_OFFS, RCC_RESET, 1'b0);
      $display("test switch done");

      // Extended register takes over divisor and then hands it back
      wr_sw(RUN_CLOCK_CONFIG_EXT_OFFS, 32'h9500_0050, 1'b1);
      axi_rd(RUN_CLOCK_CONFIG_EXT_OFFS, rd, rr);
      check(rd, 32'h9500_0050, "run_clock_config_ext data");
      check(sys_div, 6'h2a, "ext divisor");
      check(osc_src, 3'h5, "ext osc");
      check(pll_pll_power_down, 1'b0, "ext pll_power_down");
      wr_sw(RUN_CLOCK_CONFIG_EXT_OFFS, 32'h0000_0000, 1'b0);
      check(sys_div, 6'h0f, "base divisor");
      check(pll_pll_power_down, 1'b1, "base pll_power_down");
      $display("test extended done");

      // Reset in mid-run after the crystal code was moved
      axi_wr(RCC_OFFS, RCC_RESET & ~32'h0000_03c0, 4'hf, br);
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      reset_check();
      $display("test second reset done");
      end_of_test();
   end

endmodule
